// File: cmpc_chan.sv
// One comparator channel: input filter, polarity, timer latch, edges
`timescale 1ns/100ps
module cmpc_chan
  import cmpc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Analog core result, high while plus input is above minus
  input wire logic cmp_raw_i,
  // Control side
  cmpc_chan_if.chan cif
);

  logic raw_s1_q, raw_s2_q, raw_s3_q, raw_f_q, raw_f_d;
  logic core_res, inv_res, fwd_res;
  logic tmr_q, tmr_d, res_q, res_d, prev_q;

  // ==========================================================
  // Input filter: change accepted when stages two and three agree
  assign raw_f_d = (raw_s2_q == raw_s3_q) ? raw_s3_q : raw_f_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      raw_s1_q <= 1'b0;
      raw_s2_q <= 1'b0;
      raw_s3_q <= 1'b0;
      raw_f_q <= 1'b0;
    end else begin
      raw_s1_q <= cmp_raw_i;
      raw_s2_q <= raw_s1_q;
      raw_s3_q <= raw_s2_q;
      raw_f_q <= raw_f_d;
    end
  end

  // ==========================================================
  // Result path
  // disabled core yields low
  assign core_res = cif.en & raw_f_q;
  assign inv_res = core_res ^ cif.inv;
  // latch on prescaled timer falling edge
  assign tmr_d = cif.timer_fall ? inv_res : tmr_q;
  assign fwd_res = cif.sync ? tmr_q : inv_res;
  // internal copy once per instruction cycle
  assign res_d = cif.instr_tick ? fwd_res : res_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      tmr_q <= 1'b0;
      res_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      res_q <= res_d;
      prev_q <= res_q;
    end
  end

  // pin path unlatched unless timer aligned
  assign cif.pin_out = fwd_res;
  assign cif.result = res_q;
  // edges seen on the latched, inverted result
  assign cif.res_rise = res_q & ~prev_q;
  assign cif.res_fall = ~res_q & prev_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  tmr_hold_a: assert property (
    cif.sync && !cif.timer_fall |=> $stable(tmr_q))
    else $error("timer latch moved without a timer falling edge");
  inv_flip_a: assert property (
    !cif.sync && !$past(cif.sync) && $changed(cif.inv)
      && $stable(core_res) |-> $changed(cif.pin_out))
    else $error("polarity change did not flip the pin output");
  tick_only_a: assert property (
    !cif.instr_tick |=> $stable(res_q))
    else $error("internal result moved between instruction cycles");

endmodule : cmpc_chan

// File: cmpc_chan_if.sv
// Carrier between the control core and one comparator channel
`timescale 1ns/100ps
interface cmpc_chan_if;
  logic en;
  logic inv;
  logic sync;
  logic timer_fall;
  logic instr_tick;
  logic result;
  logic pin_out;
  logic res_rise;
  logic res_fall;

  modport ctl (
    output en, inv, sync, timer_fall, instr_tick,
    input result, pin_out, res_rise, res_fall
  );
  modport chan (
    input en, inv, sync, timer_fall, instr_tick,
    output result, pin_out, res_rise, res_fall
  );
endinterface : cmpc_chan_if

// File: cmpc_far_model.sv
// Behavioural analog comparator cores and timer one clock source
`timescale 1ns/100ps
module cmpc_far_model
  import cmpc_pkg::*;
#(
  parameter int HYST_MV = 10,
  parameter real TMR_HALF = 37.0
)(
  // Commanded input levels in millivolts
  input wire logic signed [15:0] vp_i [NUM_CMP],
  input wire logic signed [15:0] vn_i [NUM_CMP],
  // Controls from the block
  input wire logic [NUM_CMP-1:0] mux_connect_i,
  input wire logic [NUM_CMP-1:0] hyst_on_i,
  input wire logic tmr_run_i,
  // Core results and timer clock
  output logic [NUM_CMP-1:0] cmp_raw_o,
  output logic timer_one_clk_o
);
  // ==========================================================
  // Cores
  int diff;
  int band;
  initial cmp_raw_o = '0;
  initial timer_one_clk_o = 1'b0;
  always #1 begin
    for (int n = 0; n < NUM_CMP; n++) begin
      diff = int'(vp_i[n]) - int'(vn_i[n]);
      band = hyst_on_i[n] ? HYST_MV : 0;
      if (mux_connect_i[n] !== 1'b1) cmp_raw_o[n] = 1'b0;
      else if (diff > band) cmp_raw_o[n] = 1'b1;
      else if (diff < -band) cmp_raw_o[n] = 1'b0;
    end
  end
  // ==========================================================
  // Timer clock
  // prescaled clock source
  // Stands low between runs, so no stray falling edges
  always #(TMR_HALF) timer_one_clk_o = tmr_run_i ? ~timer_one_clk_o : 1'b0;
endmodule : cmpc_far_model

// File: cmpc_pkg.sv
// Shared constants for the comparator output control block
package cmpc_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_CMP = 2;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned ROUTE_W = 5;
  localparam int unsigned ADC_SEL_W = 5;
  localparam int unsigned INSTR_CLKS = 4;

  // ==========================================================
  // Register indexes, byte address is four times the index
  localparam logic [13:0] IDX_CH_BASE = 14'h080C;
  localparam logic [13:0] IDX_CH_STRIDE = 14'h0004;
  localparam logic [13:0] OFF_CON0 = 14'h0000;
  localparam logic [13:0] OFF_CON1 = 14'h0001;
  localparam logic [13:0] OFF_NSEL = 14'h0002;
  localparam logic [13:0] OFF_PSEL = 14'h0003;
  localparam logic [13:0] IDX_MIRROR = 14'h081F;
  localparam logic [13:0] IDX_IRQ_FLAG = 14'h0820;
  localparam logic [13:0] IDX_IRQ_EN = 14'h0821;

  // ==========================================================
  // Field positions
  localparam int unsigned EN_BIT = 7;
  localparam int unsigned OUT_BIT = 6;
  localparam int unsigned INV_BIT = 4;
  localparam int unsigned SEP_BIT = 1;
  localparam int unsigned SYNC_BIT = 0;
  localparam int unsigned RISE_BIT = 1;
  localparam int unsigned FALL_BIT = 0;
  localparam int unsigned GLB_BIT = 7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================
  // Noninverting source codes and one-hot route positions
  localparam logic [2:0] PSEL_PIN = 3'h0;
  localparam logic [2:0] PSEL_DAC1 = 3'h4;
  localparam logic [2:0] PSEL_DAC2 = 3'h5;
  localparam logic [2:0] PSEL_VREF = 3'h6;
  localparam logic [2:0] PSEL_GND = 3'h7;
  localparam int unsigned RT_PIN = 0;
  localparam int unsigned RT_DAC1 = 1;
  localparam int unsigned RT_DAC2 = 2;
  localparam int unsigned RT_VREF = 3;
  localparam int unsigned RT_GND = 4;

  // ==========================================================
  // ADC trigger select codes naming a comparator
  localparam logic [4:0] ADC_TRIG_CMP1 = 5'h1B;
  localparam logic [4:0] ADC_TRIG_CMP2 = 5'h1C;

endpackage : cmpc_pkg

// File: cmpc_top.sv
// Comparator output control: Wishbone registers, gating, events
//
// Contract
// - Disabled comparator disconnects its input selections and outputs low, or high with invert set.
// - Raw result is high when plus input exceeds minus input.
// - Invert bit set complements the result, clear passes it unchanged.
// - Each result readable in its control register and in a mirror.
// - Internal result latched each instruction cycle; pin path unlatched.
// - Timer-aligned mode latches the result on timer clock falling edges.
// - Timer-aligned latching uses the prescaled timer clock.
// - Timer counts on the rising edge, opposite to result capture.
// - Input separation bit switches hysteresis on, clear switches it off.
// - Enabled rising or falling result edge sets the interrupt flag.
// - Flag stays set until software clears it.
// - Toggling invert raises an edge event even while disabled.
// - Request needs enable, edge enable, interrupt enable, global enable.
// - Separate select fields choose plus and minus input sources.
// - Plus codes: 000 pin, 100/101 DACs, 110 reference, 111 ground.
// - Mirror holds comparator one in bit 0, two in bit 1.
// - Selected comparator rising output starts an ADC conversion.
`timescale 1ns/100ps
module cmpc_top
  import cmpc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator cores
  input wire logic [NUM_CMP-1:0] cmp_raw_i,
  output logic [NUM_CMP-1:0] mux_connect_o,
  output logic [NUM_CMP-1:0] hyst_on_o,
  output logic [NUM_CMP*SEL_W-1:0] plus_input_select_o,
  output logic [NUM_CMP*SEL_W-1:0] minus_input_select_o,
  output logic [NUM_CMP*ROUTE_W-1:0] plus_route_o,
  // Pin outputs and timer one
  output logic [NUM_CMP-1:0] cmp_pin_o,
  input wire logic timer_one_clk_i,
  output logic timer_one_count_o,
  // Processor interrupt and ADC trigger
  output logic irq_o,
  input wire logic [ADC_SEL_W-1:0] adc_trigger_select_i,
  output logic adc_start_o
);

  // ==========================================================
  // Bus decode
  logic ack_q;
  logic [31:0] dat_q;
  logic [13:0] idx;
  logic req, wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  assign idx = wb_adr_i[15:2];
  assign req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // ==========================================================
  // Control registers
  logic [NUM_CMP-1:0] en_q, inv_q, sep_q, sync_q, rise_q, fall_q;
  logic [NUM_CMP-1:0] flag_q, flag_d, flag_clr, flag_set, ie_q;
  logic [NUM_CMP-1:0] result, irq_vec, adc_vec;
  logic [SEL_W-1:0] psel_q [NUM_CMP];
  logic [SEL_W-1:0] nsel_q [NUM_CMP];
  logic [7:0] rd_part [NUM_CMP];
  logic [7:0] rd_ch;
  logic glb_ie_q;
  logic hit_mirror, hit_flag, hit_ie;

  // Timer clock filter and instruction cycle counter
  logic t_s1_q, t_s2_q, t_s3_q, t_f_q, t_f_d;
  logic t_fall_q, t_rise_q;
  logic [1:0] icnt_q;
  logic instr_tick;

  assign t_f_d = (t_s2_q == t_s3_q) ? t_s3_q : t_f_q;
  assign instr_tick = (icnt_q == 2'(INSTR_CLKS - 1));

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      t_s1_q <= 1'b0;
      t_s2_q <= 1'b0;
      t_s3_q <= 1'b0;
      t_f_q <= 1'b0;
    end else begin
      t_s1_q <= timer_one_clk_i;
      t_s2_q <= t_s1_q;
      t_s3_q <= t_s2_q;
      t_f_q <= t_f_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      t_fall_q <= 1'b0;
      t_rise_q <= 1'b0;
      icnt_q <= 2'h0;
    end else begin
      // input is the timer clock after its prescaler
      t_fall_q <= t_f_q & ~t_f_d;
      // count strobe on the opposite edge
      t_rise_q <= ~t_f_q & t_f_d;
      icnt_q <= instr_tick ? 2'h0 : icnt_q + 2'h1;
    end
  end

  assign timer_one_count_o = t_rise_q;

  // ==========================================================
  // Per-comparator logic
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      localparam logic [13:0] CH_IDX =
        IDX_CH_BASE + 14'(gi) * IDX_CH_STRIDE;
      logic hit_con0, hit_con1, hit_nsel, hit_psel;
      logic [7:0] con0_rd, con1_rd;
      cmpc_chan_if cif ();

      assign hit_con0 = (idx == CH_IDX + OFF_CON0);
      assign hit_con1 = (idx == CH_IDX + OFF_CON1);
      assign hit_nsel = (idx == CH_IDX + OFF_NSEL);
      assign hit_psel = (idx == CH_IDX + OFF_PSEL);

      always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
          en_q[gi] <= 1'b0;
          inv_q[gi] <= 1'b0;
          sep_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          rise_q[gi] <= 1'b0;
          fall_q[gi] <= 1'b0;
          psel_q[gi] <= PSEL_PIN;
          nsel_q[gi] <= PSEL_PIN;
        end else if (wr_en) begin
          if (hit_con0) begin
            en_q[gi] <= wbyte[EN_BIT];
            inv_q[gi] <= wbyte[INV_BIT];
            sep_q[gi] <= wbyte[SEP_BIT];
            sync_q[gi] <= wbyte[SYNC_BIT];
          end
          if (hit_con1) begin
            rise_q[gi] <= wbyte[RISE_BIT];
            fall_q[gi] <= wbyte[FALL_BIT];
          end
          if (hit_nsel)
            nsel_q[gi] <= wbyte[SEL_W-1:0];
          if (hit_psel)
            psel_q[gi] <= wbyte[SEL_W-1:0];
        end
      end

      assign cif.en = en_q[gi];
      assign cif.inv = inv_q[gi];
      assign cif.sync = sync_q[gi];
      assign cif.timer_fall = t_fall_q;
      assign cif.instr_tick = instr_tick;

      cmpc_chan u_chan (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .cmp_raw_i (cmp_raw_i[gi]),
        .cif (cif)
      );

      assign result[gi] = cif.result;
      assign cmp_pin_o[gi] = cif.pin_out;

      assign mux_connect_o[gi] = en_q[gi];
      assign hyst_on_o[gi] = sep_q[gi];
      assign plus_input_select_o[gi*SEL_W +: SEL_W] = psel_q[gi];
      assign minus_input_select_o[gi*SEL_W +: SEL_W] = nsel_q[gi];
      // plus source decode, unconnected codes route nothing
      assign plus_route_o[gi*ROUTE_W + RT_PIN] =
        en_q[gi] & (psel_q[gi] == PSEL_PIN);
      assign plus_route_o[gi*ROUTE_W + RT_DAC1] =
        en_q[gi] & (psel_q[gi] == PSEL_DAC1);
      assign plus_route_o[gi*ROUTE_W + RT_DAC2] =
        en_q[gi] & (psel_q[gi] == PSEL_DAC2);
      assign plus_route_o[gi*ROUTE_W + RT_VREF] =
        en_q[gi] & (psel_q[gi] == PSEL_VREF);
      assign plus_route_o[gi*ROUTE_W + RT_GND] =
        en_q[gi] & (psel_q[gi] == PSEL_GND);

      // enabled edges of the inverted result
      assign flag_set[gi] = (cif.res_rise & rise_q[gi])
        | (cif.res_fall & fall_q[gi]);
      assign flag_clr[gi] = wr_en & hit_flag & wbyte[gi];
      // comparator enable, interrupt enable and at least one edge enable must be set
      assign irq_vec[gi] = flag_q[gi] & ie_q[gi] & en_q[gi]
        & (rise_q[gi] | fall_q[gi]);
      // ADC start on the named comparator rising
      assign adc_vec[gi] = cif.res_rise & (adc_trigger_select_i ==
        (gi == 0 ? ADC_TRIG_CMP1 : ADC_TRIG_CMP2));

      // result readable in its own control register
      assign con0_rd = {en_q[gi], result[gi], 1'b0, inv_q[gi],
        2'b00, sep_q[gi], sync_q[gi]};
      assign con1_rd = {6'h00, rise_q[gi], fall_q[gi]};
      assign rd_part[gi] = hit_con0 ? con0_rd
        : hit_con1 ? con1_rd
        : hit_nsel ? {5'h00, nsel_q[gi]}
        : hit_psel ? {5'h00, psel_q[gi]}
        : RST_BYTE;
    end
  endgenerate

  // ==========================================================
  // Interrupt flags and enables
  assign hit_mirror = (idx == IDX_MIRROR);
  assign hit_flag = (idx == IDX_IRQ_FLAG);
  assign hit_ie = (idx == IDX_IRQ_EN);
  // sticky flag, a new edge beats a same-cycle clear
  assign flag_d = (flag_q & ~flag_clr) | flag_set;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      flag_q <= '0;
      ie_q <= '0;
      glb_ie_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      if (wr_en && hit_ie) begin
        ie_q <= wbyte[NUM_CMP-1:0];
        glb_ie_q <= wbyte[GLB_BIT];
      end
    end
  end

  // global enable gates the processor request
  assign irq_o = glb_ie_q & (|irq_vec);
  assign adc_start_o = |adc_vec;

  // ==========================================================
  // Read path and acknowledge
  always_comb begin
    rd_ch = RST_BYTE;
    for (int i = 0; i < NUM_CMP; i++)
      rd_ch = rd_ch | rd_part[i];
  end

  // mirror holds comparator n in bit n-1
  assign rd_byte = hit_mirror ? {6'h00, result}
    : hit_flag ? {6'h00, flag_q}
    : hit_ie ? {glb_ie_q, 5'h00, ie_q}
    : rd_ch;

  // Single wait state; unmapped reads answer zero
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      dat_q <= RST_WORD;
    end else begin
      ack_q <= req & ~ack_q;
      dat_q <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  dis_pin_low_a: assert property (
    (!en_q[0] && !inv_q[0] && !sync_q[0]) |-> !cmp_pin_o[0])
    else $error("disabled comparator drives its pin high");
  mirror_read_a: assert property (
    req && !ack_q && !wb_we_i && hit_mirror
      |=> wb_ack_o && wb_dat_o[1:0] == $past(result))
    else $error("mirror read does not match the results");
  flag_sticky_a: assert property (
    flag_q[0] && !flag_clr[0] |=> flag_q[0])
    else $error("interrupt flag dropped without a clear");
  edge_flag_a: assert property (
    flag_set[1] |=> flag_q[1])
    else $error("enabled edge did not set the flag");
  irq_gate_a: assert property (
    irq_o |-> glb_ie_q && (|(ie_q & en_q & flag_q)))
    else $error("request raised with an enable missing");
  ack_pulse_a: assert property (
    req && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
    else $error("acknowledge not a single cycle pulse");
  adc_start_a: assert property (
    adc_start_o |-> adc_trigger_select_i == ADC_TRIG_CMP1
      || adc_trigger_select_i == ADC_TRIG_CMP2)
    else $error("ADC start without a comparator trigger select");
  tick_period_a: assert property (
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick period wrong");
  route_off_a: assert property (
    !en_q[1] |-> plus_route_o[2*ROUTE_W-1:ROUTE_W] == '0)
    else $error("disabled comparator still routes a plus source");

  edge_irq_c: cover property (flag_set[0] ##[1:20] irq_o);
  adc_trig_c: cover property (adc_start_o);
  sync_mode_c: cover property (sync_q[0] && t_fall_q);

endmodule : cmpc_top

// File: comparator_output_control_test.sv
// Self-checking bench for the comparator output control block
`timescale 1ns/100ps
module comparator_output_control_test
  import cmpc_pkg::*;
;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [NUM_CMP-1:0] raw, mux_c, hyst, pin;
  logic [NUM_CMP*SEL_W-1:0] psel, nsel;
  logic [NUM_CMP*ROUTE_W-1:0] route;
  logic tclk, tcount, irq, adc_go;
  logic tmr_run = 1'b0;
  logic [4:0] adc_sel = 5'h00;
  logic signed [15:0] vp [NUM_CMP] = '{16'sh0000, 16'sh0000};
  logic signed [15:0] vn [NUM_CMP] = '{16'sh0064, 16'sh0064};
  logic [31:0] q;
  int fails = 0;
  int cmp_count = 0;
  int adc_n = 0;
  int tmr_n = 0;
  logic [2:0] codes [5] = '{PSEL_PIN, PSEL_DAC1, PSEL_DAC2, PSEL_VREF,
    PSEL_GND};
  int pos [5] = '{RT_PIN, RT_DAC1, RT_DAC2, RT_VREF, RT_GND};

  always #4 mclk_i = ~mclk_i;

  cmpc_top u_cmpc_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_raw_i(raw),
    .mux_connect_o(mux_c), .hyst_on_o(hyst), .plus_input_select_o(psel),
    .minus_input_select_o(nsel), .plus_route_o(route), .cmp_pin_o(pin),
    .timer_one_clk_i(tclk), .timer_one_count_o(tcount), .irq_o(irq),
    .adc_trigger_select_i(adc_sel), .adc_start_o(adc_go));

  cmpc_far_model u_cmpc_far_model (.vp_i(vp), .vn_i(vn),
    .mux_connect_i(mux_c), .hyst_on_i(hyst), .tmr_run_i(tmr_run),
    .cmp_raw_o(raw), .timer_one_clk_o(tclk));

  always @(posedge mclk_i) begin
    if (adc_go === 1'b1) adc_n++;
    if (tcount === 1'b1) tmr_n++;
  end

  // ==========================================================
  // Tasks
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [13:0] ri(input int n, input logic [13:0] off);
    return IDX_CH_BASE + IDX_CH_STRIDE * 14'(n) + off;
  endfunction : ri

  // Holds the request until ack is sampled high, then one idle cycle
  task automatic wb(input logic [13:0] idx, input logic w,
      input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    @(posedge mclk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      n++;
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      fails++;
      finish_test();
    end
    @(posedge mclk_i);
  endtask : wb

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(idx, 1'b1, d, r);
  endtask : wr

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] e);
    logic [31:0] r;
    wb(idx, 1'b0, 8'h00, r);
    chk(r, {24'h00_0000, e});
  endtask : rd_chk

  // Covers input filter, tick latch and edge stage latency
  // wait out the response interval
  task automatic settle();
    repeat (16) @(posedge mclk_i);
  endtask : settle

  // ==========================================================
  // Sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    rd_chk(ri(0, OFF_CON0), RST_BYTE);
    rd_chk(ri(1, OFF_CON1), RST_BYTE);
    rd_chk(IDX_IRQ_FLAG, RST_BYTE);
    rd_chk(14'h0700, 8'h00);
    wr(ri(0, OFF_CON0), 8'h80);
    chk(mux_c, 2'b01);
    vp[0] <= 16'sh00C8;
    settle();
    rd_chk(ri(0, OFF_CON0), 8'hC0);
    rd_chk(IDX_MIRROR, 8'h01);
    chk(pin, 2'b01);
    wr(ri(0, OFF_CON0), 8'h90);
    settle();
    rd_chk(ri(0, OFF_CON0), 8'h90);
    chk(pin, 2'b00);
    wr(ri(0, OFF_CON0), 8'h80);
    settle();
    rd_chk(IDX_IRQ_FLAG, 8'h00);
    wr(ri(0, OFF_CON1), 8'h02);
    wr(IDX_IRQ_EN, 8'h81);
    vp[0] <= 16'sh0000;
    settle();
    rd_chk(IDX_IRQ_FLAG, 8'h00);
    adc_sel <= ADC_TRIG_CMP1;
    vp[0] <= 16'sh00C8;
    settle();
    rd_chk(IDX_IRQ_FLAG, 8'h01);
    chk(irq, 1'b1);
    chk(adc_n, 1);
    vp[0] <= 16'sh0000;
    settle();
    rd_chk(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_IRQ_EN, 8'h01);
    chk(irq, 1'b0);
    wr(IDX_IRQ_FLAG, 8'h01);
    rd_chk(IDX_IRQ_FLAG, 8'h00);
    wr(ri(0, OFF_CON1), 8'h01);
    vp[0] <= 16'sh00C8;
    settle();
    rd_chk(IDX_IRQ_FLAG, 8'h00);
    vp[0] <= 16'sh0000;
    settle();
    rd_chk(IDX_IRQ_FLAG, 8'h01);
    wr(IDX_IRQ_FLAG, 8'h01);
    wr(ri(1, OFF_CON1), 8'h02);
    wr(IDX_IRQ_EN, 8'h82);
    wr(ri(1, OFF_CON0), 8'h10);
    settle();
    rd_chk(ri(1, OFF_CON0), 8'h50);
    rd_chk(IDX_IRQ_FLAG, 8'h02);
    chk(irq, 1'b0);
    chk(route[9:5], 5'h00);
    wr(IDX_IRQ_FLAG, 8'h02);
    for (int i = 0; i < 5; i++) begin
      wr(ri(0, OFF_PSEL), {5'h00, codes[i]});
      chk(route[4:0], 5'h01 << pos[i]);
      chk(psel[2:0], codes[i]);
    end
    wr(ri(0, OFF_PSEL), 8'h03);
    chk(route[4:0], 5'h00);
    wr(ri(0, OFF_NSEL), 8'h05);
    chk(nsel[2:0], 3'h5);
    rd_chk(ri(0, OFF_NSEL), 8'h05);
    wr(ri(0, OFF_CON0), 8'h82);
    chk(hyst, 2'b01);
    vp[0] <= 16'sh0069;
    settle();
    rd_chk(ri(0, OFF_CON0), 8'h82);
    wr(ri(0, OFF_CON0), 8'h80);
    settle();
    rd_chk(ri(0, OFF_CON0), 8'hC0);
    wr(ri(0, OFF_CON0), 8'h81);
    settle();
    chk(pin, 2'b10);
    tmr_run <= 1'b1;
    repeat (64) @(posedge mclk_i);
    chk(pin, 2'b11);
    chk(tmr_n > 0, 1);
    tmr_run <= 1'b0;
    nrst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    chk(mux_c, 2'b00);
    rd_chk(ri(0, OFF_CON0), RST_BYTE);
    rd_chk(IDX_IRQ_FLAG, RST_BYTE);
    finish_test();
  end
endmodule : comparator_output_control_test
